// ### design/dma_arb_cfg.svh
// register indices, field positions, reset values and limits of the channel arbiter
`ifndef DMA_ARB_CFG_SVH
`define DMA_ARB_CFG_SVH
// register indices; byte address is four times the index
`define IDX_CTRL        4'h0
`define IDX_PENDING     4'h1
`define IDX_BUSY        4'h2
`define IDX_ACTIVE      4'h3
`define IDX_CH_ENABLE   4'h4
`define IDX_CH_SUSPEND  4'h5
`define IDX_CH_RESUME   4'h6
`define IDX_CH_LEVEL    4'h7
`define IDX_INT_ENABLE  4'h8
`define IDX_INT_FLAG    4'h9
`define IDX_CH_STATUS   4'hA
`define IDX_DEBUG_HALT  4'hD
// field positions
`define CTRL_SWRST_BIT  0
`define CTRL_LVLEN_LSB  8
`define DBG_RUN_BIT     0
`define HI_FIELD_LSB    8
// reset values
`define RST_LVLEN       4'h0
`define RST_RUN_DBG     1'b0
// limits
`define MAX_CHANNELS    8
`define NUM_LEVELS      4
`endif

// ### design/dma_arb_pkg.sv
// types shared by the channel arbiter and its surroundings
`default_nettype none
package dma_arb_pkg;
   typedef enum logic [1:0] {
      CMD_DATA  = 2'b00,
      CMD_FETCH = 2'b01,
      CMD_WBACK = 2'b10
   } cmd_kind_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01
   } eng_state_t;
   typedef struct packed {
      cmd_kind_t  kind;
      logic [2:0] chan;
   } mover_cmd_t;
   typedef struct packed {
      logic valid;
      logic err;
      logic block_done;
      logic desc_valid;
      logic next_null;
   } mover_rsp_t;
   typedef struct packed {
      logic [3:0]  lvlen;
      logic        run_dbg;
      logic [7:0]  en;
      logic [7:0]  suspend_flag;
      logic [7:0]  pend;
      logic [7:0]  busy;
      logic [15:0] lvl;
      logic [7:0]  transfer_error_flag_en;
      logic [7:0]  suspend_flag_en;
      logic [7:0]  transfer_error_flag;
      logic [7:0]  suspf;
      logic [7:0]  fetch_error_bit;
      logic [7:0]  next_null;
      eng_state_t  st;
      cmd_kind_t   kind;
      logic [2:0]  act;
      mover_cmd_t  buf0;
      mover_cmd_t  buf1;
      logic [1:0]  cnt;
      logic        wr_ph;
      logic [3:0]  widx;
      logic [31:0] rdata;
   } arb_state_t;
endpackage
`default_nettype wire

// ### design/dma_chan_arbiter.sv
// channel arbiter, error handling, descriptor chaining and debug halt of the dma controller
`timescale 1ns/100ps
`default_nettype none
`include "dma_arb_cfg.svh"

// What this block does
// [RQ1] trigger on enabled, unsuspended channel sets its pending bit and queues it
// [RQ2] arbiter picks next channel by scheme; grant clears its pending bit
// [RQ3] first granted transfer sets busy; busy stays set for later grants
// [RQ4] after transfer: requeue keeping busy, or wait/suspend/disable clearing busy
// [RQ5] suspend drops channel from queue keeping pending; resume requeues it
// [RQ6] disabling a pending channel removes it and clears pending
// [RQ7] level executing bit set while a channel of that level pends or transfers
// [RQ8] four priority levels per channel; higher level number wins
// [RQ9] a level takes part in arbitration only when its level enable is set
// [RQ10] bus error disables channel, sets transfer error flag, interrupt if enabled
// [RQ11] on bus error counter is written back undecremented before disabling
// [RQ12] invalid descriptor or null next on resume suspends with flags and interrupt
// [RQ13] blocks chain via next address; null next ends the transaction
// [RQ14] software appends by writing new null-terminated descriptor then relinking
// [RQ15] software enables suspend interrupt and channel before inserting descriptors
// [RQ16] debug run bit 0 halts controller under debug; kept by software reset
// [RQ17] ties within the top enabled level go to the lowest channel number
module dma_chan_arbiter #(
   parameter int NCH = 4
) (
   input  wire logic                    clk_sys,
   input  wire logic                    rst,
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [31:0]             hwdata,
   input  wire logic                    hready,
   output logic                         hreadyout,
   output logic                         hresp,
   output logic [31:0]                  hrdata,
   input  wire logic [7:0]              trig,
   input  wire logic                    dbg_halt,
   output logic                         cmd_valid,
   input  wire logic                    cmd_ready,
   output dma_arb_pkg::mover_cmd_t      cmd,
   input  wire dma_arb_pkg::mover_rsp_t rsp,
   output logic                         transfer_error_flag_irq,
   output logic                         suspend_flag_irq
);
   import dma_arb_pkg::*;

   // refuse channel counts the masks and indices cannot serve
   if (NCH < 1 || NCH > `MAX_CHANNELS) begin : g_bad_nch
      $error("NCH must be 1 to 8");
   end

   //--------------------------------------------------------------
   // state
   //--------------------------------------------------------------
   arb_state_t s_ff;
   arb_state_t nxt_s;
   logic [7:0] ch_mask;
   logic [3:0] lvlex;
   logic       halted;
   logic       grant;
   logic [2:0] gch;

   assign ch_mask = 8'(({8'h0, 8'hFF} << NCH) >> 8);
   assign halted  = dbg_halt && !s_ff.run_dbg; // see [RQ16]

   // level executing status from pending and active channels
   always_comb begin
      lvlex = 4'h0;
      for (int c = 0; c < `MAX_CHANNELS; c++) begin
         if ((s_ff.pend[c] && s_ff.en[c] && !s_ff.suspend_flag[c] && ch_mask[c]) ||
             (s_ff.st == ST_WAIT && s_ff.act == 3'(c))) begin
            lvlex[s_ff.lvl[2*c +: 2]] = 1'b1; // see [RQ7]
         end
      end
   end

   // arbiter: highest enabled level, lowest channel inside it
   always_comb begin
      grant = 1'b0;
      gch   = 3'h0;
      for (int l = `NUM_LEVELS - 1; l >= 0; l--) begin
         for (int c = 0; c < `MAX_CHANNELS; c++) begin
            if (!grant && s_ff.lvlen[l] && ch_mask[c] && s_ff.pend[c] && // see [RQ9]
                s_ff.en[c] && !s_ff.suspend_flag[c] && s_ff.lvl[2*c +: 2] == 2'(l)) begin
               grant = 1'b1; // see [RQ8]
               gch   = 3'(c); // see [RQ17]
            end
         end
      end
      if (s_ff.st != ST_IDLE || halted || s_ff.cnt == 2'h2) begin
         grant = 1'b0;
      end
   end

   //--------------------------------------------------------------
   // next state
   //--------------------------------------------------------------
   always_comb begin
      logic       wr;
      logic       push;
      logic       pop;
      mover_cmd_t pcmd;
      logic [7:0] wlo;
      logic [7:0] whi;
      wr   = s_ff.wr_ph;
      push = 1'b0;
      pop  = (s_ff.cnt != 2'h0) && cmd_ready;
      pcmd = '{kind: CMD_DATA, chan: 3'h0};
      wlo  = hwdata[7:0] & ch_mask;
      whi  = hwdata[15:8] & ch_mask;
      nxt_s = s_ff;
      nxt_s.wr_ph = 1'b0;

      // register writes in the data phase
      if (wr) begin
         unique case (s_ff.widx)
            `IDX_CTRL: begin
               nxt_s.lvlen = hwdata[`CTRL_LVLEN_LSB +: 4];
            end
            `IDX_CH_ENABLE: begin
               nxt_s.en   = wlo;
               nxt_s.pend = s_ff.pend & wlo; // see [RQ6]
               nxt_s.busy = s_ff.busy & wlo; // see [RQ4]
            end
            `IDX_CH_SUSPEND: begin
               nxt_s.suspend_flag = s_ff.suspend_flag | wlo; // see [RQ5]
               for (int c = 0; c < `MAX_CHANNELS; c++) begin
                  if (wlo[c] && !(s_ff.st == ST_WAIT && s_ff.act == 3'(c))) begin
                     nxt_s.busy[c] = 1'b0; // see [RQ4]
                  end
               end
            end
            `IDX_CH_RESUME: begin
               for (int c = 0; c < `MAX_CHANNELS; c++) begin
                  if (wlo[c] && s_ff.next_null[c]) begin
                     nxt_s.suspf[c] = 1'b1; // see [RQ12]
                     nxt_s.fetch_error_bit[c]  = 1'b1;
                  end else if (wlo[c]) begin
                     nxt_s.suspend_flag[c] = 1'b0; // see [RQ5]
                     nxt_s.fetch_error_bit[c] = 1'b0;
                  end
               end
            end
            `IDX_CH_LEVEL: begin
               nxt_s.lvl = hwdata[15:0];
            end
            `IDX_INT_ENABLE: begin
               nxt_s.transfer_error_flag_en = wlo;
               nxt_s.suspend_flag_en = whi;
            end
            `IDX_INT_FLAG: begin
               nxt_s.transfer_error_flag  = s_ff.transfer_error_flag & ~wlo;
               nxt_s.suspf = s_ff.suspf & ~whi;
            end
            `IDX_DEBUG_HALT: begin
               nxt_s.run_dbg = hwdata[`DBG_RUN_BIT];
            end
            default: begin
            end
         endcase
      end

      // grant starts one transfer of the chosen channel
      if (grant) begin
         nxt_s.pend[gch] = 1'b0; // see [RQ2]
         nxt_s.busy[gch] = 1'b1; // see [RQ3]
         nxt_s.act       = gch;
         nxt_s.kind      = CMD_DATA;
         nxt_s.st        = ST_WAIT;
         push            = 1'b1;
         pcmd            = '{kind: CMD_DATA, chan: gch};
      end

      // answer from the mover ends the outstanding command
      if (s_ff.st == ST_WAIT && rsp.valid) begin
         nxt_s.st = ST_IDLE;
         unique case (s_ff.kind)
            CMD_DATA: begin
               if (rsp.err) begin
                  nxt_s.transfer_error_flag[s_ff.act] = 1'b1; // see [RQ10]
                  nxt_s.kind = CMD_WBACK;      // see [RQ11]
                  nxt_s.st   = ST_WAIT;
                  push       = 1'b1;
                  pcmd       = '{kind: CMD_WBACK, chan: s_ff.act};
               end else if (!rsp.block_done) begin
                  nxt_s.pend[s_ff.act] = 1'b1; // see [RQ4]
               end else if (s_ff.next_null[s_ff.act]) begin
                  nxt_s.busy[s_ff.act] = 1'b0; // see [RQ13]
               end else begin
                  nxt_s.kind = CMD_FETCH; // see [RQ13]
                  nxt_s.st   = ST_WAIT;
                  push       = 1'b1;
                  pcmd       = '{kind: CMD_FETCH, chan: s_ff.act};
               end
            end
            CMD_FETCH: begin
               nxt_s.busy[s_ff.act] = 1'b0;
               if (!rsp.desc_valid) begin
                  nxt_s.suspend_flag[s_ff.act]  = 1'b1; // see [RQ12]
                  nxt_s.suspf[s_ff.act] = 1'b1;
                  nxt_s.fetch_error_bit[s_ff.act]  = 1'b1;
               end else begin
                  nxt_s.next_null[s_ff.act] = rsp.next_null;
               end
            end
            CMD_WBACK: begin
               nxt_s.en[s_ff.act]   = 1'b0; // see [RQ10]
               nxt_s.pend[s_ff.act] = 1'b0;
               nxt_s.busy[s_ff.act] = 1'b0;
            end
            default: begin
               nxt_s.st = ST_IDLE;
            end
         endcase
      end

      // triggers after grant and answers so a set wins over the grant's same-cycle clear; a software reset still clears it
      for (int c = 0; c < `MAX_CHANNELS; c++) begin
         if (trig[c] && ch_mask[c] && nxt_s.en[c] && !nxt_s.suspend_flag[c]) begin
            nxt_s.pend[c] = 1'b1; // see [RQ1]
         end
      end

      // two-entry command buffer; a full buffer holds off the arbiter
      if (pop) begin
         nxt_s.buf0 = s_ff.buf1;
      end
      if (push) begin
         if ((s_ff.cnt == 2'h0) || (s_ff.cnt == 2'h1 && pop)) begin
            nxt_s.buf0 = pcmd;
         end else begin
            nxt_s.buf1 = pcmd;
         end
      end
      nxt_s.cnt = 2'(s_ff.cnt + {1'b0, push} - {1'b0, pop});

      // address phase of the register bus
      if (hsel && htrans[1] && hready) begin
         nxt_s.wr_ph = hwrite;
         nxt_s.widx  = haddr[5:2];
         unique case (haddr[5:2])
            `IDX_CTRL:       nxt_s.rdata = {20'h0, s_ff.lvlen, 8'h0};
            `IDX_PENDING:    nxt_s.rdata = {24'h0, s_ff.pend};
            `IDX_BUSY:       nxt_s.rdata = {24'h0, s_ff.busy};
            `IDX_ACTIVE:     nxt_s.rdata = {28'h0, lvlex};
            `IDX_CH_ENABLE:  nxt_s.rdata = {24'h0, s_ff.en};
            `IDX_CH_SUSPEND: nxt_s.rdata = {24'h0, s_ff.suspend_flag};
            `IDX_CH_LEVEL:   nxt_s.rdata = {16'h0, s_ff.lvl};
            `IDX_INT_ENABLE: nxt_s.rdata = {16'h0, s_ff.suspend_flag_en, s_ff.transfer_error_flag_en};
            `IDX_INT_FLAG:   nxt_s.rdata = {16'h0, s_ff.suspf, s_ff.transfer_error_flag};
            `IDX_CH_STATUS:  nxt_s.rdata = {16'h0, s_ff.suspend_flag, s_ff.fetch_error_bit};
            `IDX_DEBUG_HALT: nxt_s.rdata = {31'h0, s_ff.run_dbg};
            default:         nxt_s.rdata = 32'h0;
         endcase
      end

      // software reset returns everything except the debug run bit
      if (wr && s_ff.widx == `IDX_CTRL && hwdata[`CTRL_SWRST_BIT]) begin
         nxt_s         = '0;
         nxt_s.lvlen   = `RST_LVLEN;
         nxt_s.run_dbg = s_ff.run_dbg; // see [RQ16]
         nxt_s.st      = ST_IDLE;
         nxt_s.kind    = CMD_DATA;
      end
   end

   // state register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_ff         <= '0;
         s_ff.lvlen   <= `RST_LVLEN;
         s_ff.run_dbg <= `RST_RUN_DBG;
      end else begin
         s_ff <= nxt_s;
      end
   end

   //--------------------------------------------------------------
   // outputs
   //--------------------------------------------------------------
   assign hreadyout = 1'b1; // zero wait states
   assign hresp     = 1'b0; // always okay
   assign hrdata    = s_ff.rdata;
   assign cmd_valid = (s_ff.cnt != 2'h0);
   assign cmd       = s_ff.buf0;
   assign transfer_error_flag_irq  = |(s_ff.transfer_error_flag & s_ff.transfer_error_flag_en);  // see [RQ10]
   assign suspend_flag_irq  = |(s_ff.suspf & s_ff.suspend_flag_en); // see [RQ12]

   //--------------------------------------------------------------
   // checks
   //--------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   logic data_rsp;
   assign data_rsp = s_ff.st == ST_WAIT && rsp.valid && s_ff.kind == CMD_DATA;

   chk_trig_pending: assert property ( // see [RQ1]
      trig[0] && s_ff.en[0] && !s_ff.suspend_flag[0] && !s_ff.wr_ph |=> s_ff.pend[0])
      else $error("trigger did not set pending");
   chk_grant_busy: assert property ( // see [RQ3]
      grant |=> s_ff.busy[s_ff.act] && s_ff.st == ST_WAIT && cmd_valid)
      else $error("grant did not set busy and issue");
   chk_grant_clear: assert property ( // see [RQ2]
      grant && !trig[gch] |=> !s_ff.pend[$past(gch)])
      else $error("grant left pending set");
   chk_disable_clear: assert property ( // see [RQ6]
      s_ff.wr_ph && s_ff.widx == `IDX_CH_ENABLE && !hwdata[0] && !grant
      |=> !s_ff.pend[0] && !s_ff.en[0])
      else $error("disable kept channel pending");
   chk_suspend_keeps: assert property ( // see [RQ5]
      s_ff.wr_ph && s_ff.widx == `IDX_CH_SUSPEND && hwdata[0] && s_ff.pend[0] && !grant
      |=> s_ff.pend[0] && s_ff.suspend_flag[0])
      else $error("suspend dropped pending bit");
   chk_level_exec: assert property ( // see [RQ7]
      s_ff.st == ST_WAIT |-> lvlex[s_ff.lvl[2*s_ff.act +: 2]])
      else $error("level executing bit missing");
   chk_level_gate: assert property ( // see [RQ9]
      grant |-> s_ff.lvlen[s_ff.lvl[2*gch +: 2]])
      else $error("grant from disabled level");
   chk_err_wback: assert property ( // see [RQ11]
      data_rsp && rsp.err |=> s_ff.kind == CMD_WBACK && s_ff.en[s_ff.act]
      && s_ff.transfer_error_flag[s_ff.act])
      else $error("bus error without write-back");
   chk_wback_disable: assert property ( // see [RQ10]
      s_ff.st == ST_WAIT && rsp.valid && s_ff.kind == CMD_WBACK
      |=> !s_ff.en[$past(s_ff.act)] ##0 s_ff.st == ST_IDLE)
      else $error("channel not disabled after write-back");
   chk_fetch_invalid: assert property ( // see [RQ12]
      s_ff.st == ST_WAIT && rsp.valid && s_ff.kind == CMD_FETCH && !rsp.desc_valid
      |=> s_ff.suspend_flag[$past(s_ff.act)] && s_ff.fetch_error_bit[$past(s_ff.act)])
      else $error("invalid descriptor not suspended");
   chk_debug_halt: assert property ( // see [RQ16]
      dbg_halt && !s_ff.run_dbg |-> !grant)
      else $error("grant while debug halted");

   cov_chain_fetch: cover property (data_rsp && rsp.block_done ##1 s_ff.kind == CMD_FETCH);
   cov_bus_error:   cover property (data_rsp && rsp.err);
   cov_buf_full:    cover property (s_ff.cnt == 2'h2);
endmodule
`default_nettype wire

// ### testbench/mover_model.sv
// behavioural data mover that takes one command at a time and answers it
`timescale 1ns/100ps
`default_nettype none
module mover_model (
   input  wire logic                    clk_sys,
   input  wire logic                    stall,
   input  wire logic [3:0]              mode,
   input  wire logic                    cmd_valid,
   output logic                         cmd_ready,
   input  wire dma_arb_pkg::mover_cmd_t cmd,
   output dma_arb_pkg::mover_rsp_t      rsp
);
   import dma_arb_pkg::*;
   logic       busy_ff = 1'b0;
   logic [2:0] wait_ff = 3'h0;
   cmd_kind_t  kind_ff = CMD_DATA;
   // one command outstanding; higher channels answer later
   assign cmd_ready = !stall && !busy_ff;
   initial rsp = '0;
   always @(posedge clk_sys) begin
      rsp <= {1'b0, ~rsp[3:0]};  // fields carry no meaning between answers
      if (cmd_valid && cmd_ready) begin
         busy_ff <= 1'b1;
         wait_ff <= cmd.chan;
         kind_ff <= cmd.kind;
      end else if (busy_ff && wait_ff != 3'h0) begin
         wait_ff <= wait_ff - 3'h1;
      end else if (busy_ff) begin
         busy_ff <= 1'b0;
         // one-cycle answer; next address is null only when mode bit 3 is set
         rsp <= {1'b1, mode[0] && kind_ff == CMD_DATA, mode[1], mode[2], mode[3]};
      end
   end
endmodule
`default_nettype wire

// ### testbench/tb_dma_chan_arbiter.sv
// self-checking bench for the dma channel arbiter
`timescale 1ns/100ps
`default_nettype none
`include "dma_arb_cfg.svh"
module tb_dma_chan_arbiter;
   import dma_arb_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'b00;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [7:0]  trig = 8'h00;
   logic        dbg_halt = 1'b0;
   logic        stall = 1'b0;
   logic [3:0]  mode = 4'hE;
   logic        hreadyout, hresp, cmd_valid, cmd_ready, transfer_error_flag_irq, suspend_flag_irq;
   logic [31:0] hrdata;
   mover_cmd_t  cmd;
   mover_rsp_t  rsp;
   mover_cmd_t  got_q[$];
   int          n_mismatch = 0;
   int          tests_run = 0;
   int          cyc = 0;
   int          seed, w;
   logic [7:0]  lv;
   logic [3:0]  le, m, am;

   dma_chan_arbiter #(.NCH(4)) DUT (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .trig(trig), .dbg_halt(dbg_halt),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd), .rsp(rsp),
      .transfer_error_flag_irq(transfer_error_flag_irq), .suspend_flag_irq(suspend_flag_irq));
   mover_model MOVER (.clk_sys(clk_sys), .stall(stall), .mode(mode), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd(cmd), .rsp(rsp));

   always #5 clk_sys = ~clk_sys;
   // record accepted commands and cut a hang short
   always @(posedge clk_sys) begin
      if (cmd_valid === 1'b1 && cmd_ready === 1'b1) got_q.push_back(cmd);
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         final_report();
      end
   end

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // single ahb-lite word transfer; waits on hready in both phases
   task automatic bus(input logic wr_en, input logic [3:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr_en;
      haddr <= {26'h0, idx, 2'b00};
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      rd = hrdata;
   endtask
   task automatic wr(input logic [3:0] idx, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, idx, d, r);
   endtask
   task automatic chk(input logic [3:0] idx, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, idx, 32'h0, r);
      cmp(r, exp);
   endtask
   task automatic cmp_cmd(input cmd_kind_t k, input int c);
      int n;
      mover_cmd_t g;
      n = 0;
      while (got_q.size() == 0 && n < 100) begin
         @(posedge clk_sys);
         n++;
      end
      g = (got_q.size() != 0) ? got_q.pop_front() : 5'h1F;
      cmp(32'(g), 32'({k, 3'(c)}));
   endtask
   task automatic pulse(input logic [7:0] t);
      trig <= t;
      @(posedge clk_sys);
      trig <= 8'h00;
   endtask
   // highest enabled level first, lowest channel among equals
   function automatic int pick(input logic [3:0] msk);
      pick = -1;
      for (int l = 0; l < 4; l++)
         for (int c = 3; c >= 0; c--)
            if (msk[c] && le[l] && lv[2*c +: 2] == l) pick = c;
   endfunction

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      seed = 35;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      chk(`IDX_DEBUG_HALT, 32'h0);
      chk(4'hF, 32'h0);
      wr(`IDX_DEBUG_HALT, 32'h1);
      wr(`IDX_CTRL, 32'h1);
      chk(`IDX_DEBUG_HALT, 32'h1);
      wr(`IDX_CH_ENABLE, 32'h1);
      pulse(8'h01);
      chk(`IDX_PENDING, 32'h1);
      repeat (10) @(posedge clk_sys);
      cmp(32'(got_q.size()), 32'h0);
      wr(`IDX_CH_ENABLE, 32'h0);
      chk(`IDX_PENDING, 32'h0);
      $display("test registers and queue done");
      lv = 8'($random(seed));
      le = 4'($random(seed)) | (4'h1 << lv[1:0]);
      am = 4'h0;
      for (int c = 0; c < 4; c++) am[lv[2*c +: 2]] = 1'b1;
      stall <= 1'b1;
      wr(`IDX_CH_LEVEL, {24'h0, lv});
      wr(`IDX_CTRL, {20'h0, le, 8'h00});
      wr(`IDX_CH_ENABLE, 32'hF);
      pulse(8'h0F);
      // let the first grant land before the pending word is sampled
      @(posedge clk_sys);
      w = pick(4'hF);
      chk(`IDX_PENDING, 32'(4'hF ^ (4'h1 << w)));
      chk(`IDX_BUSY, 32'(4'h1 << w));
      chk(`IDX_ACTIVE, 32'(am));
      stall <= 1'b0;
      m = 4'hF;
      while (w >= 0) begin
         cmp_cmd(CMD_DATA, w);
         cmp_cmd(CMD_FETCH, w);
         m[w] = 1'b0;
         w = pick(m);
      end
      repeat (8) @(posedge clk_sys);
      chk(`IDX_PENDING, 32'(m));
      chk(`IDX_BUSY, 32'h0);
      pulse(8'h01);
      cmp_cmd(CMD_DATA, 0);
      repeat (10) @(posedge clk_sys);
      cmp(32'(got_q.size()), 32'h0);
      chk(`IDX_BUSY, 32'h0);
      $display("test arbitration done");
      wr(`IDX_CTRL, 32'h1);
      wr(`IDX_INT_ENABLE, 32'h0400);
      wr(`IDX_CH_ENABLE, 32'h4);
      pulse(8'h04);
      wr(`IDX_CH_SUSPEND, 32'h4);
      wr(`IDX_CTRL, 32'hF00);
      chk(`IDX_PENDING, 32'h4);
      repeat (10) @(posedge clk_sys);
      cmp(32'(got_q.size()), 32'h0);
      mode <= 4'h2;
      wr(`IDX_CH_RESUME, 32'h4);
      cmp_cmd(CMD_DATA, 2);
      cmp_cmd(CMD_FETCH, 2);
      repeat (8) @(posedge clk_sys);
      chk(`IDX_CH_STATUS, 32'h0404);
      chk(`IDX_INT_FLAG, 32'h0400);
      cmp(32'(suspend_flag_irq), 32'h1);
      wr(`IDX_INT_FLAG, 32'h0400);
      // the clear lands at the closing edge of the write; look one edge later
      @(posedge clk_sys);
      cmp(32'(suspend_flag_irq), 32'h0);
      $display("test suspend and fetch error done");
      mode <= 4'h1;
      wr(`IDX_INT_ENABLE, 32'h2);
      wr(`IDX_CH_ENABLE, 32'h2);
      pulse(8'h02);
      cmp_cmd(CMD_DATA, 1);
      cmp_cmd(CMD_WBACK, 1);
      repeat (8) @(posedge clk_sys);
      chk(`IDX_CH_ENABLE, 32'h0);
      chk(`IDX_INT_FLAG, 32'h2);
      cmp(32'(transfer_error_flag_irq), 32'h1);
      $display("test bus error done");
      mode <= 4'hE;
      wr(`IDX_DEBUG_HALT, 32'h0);
      dbg_halt <= 1'b1;
      wr(`IDX_CH_ENABLE, 32'h8);
      pulse(8'h08);
      repeat (10) @(posedge clk_sys);
      cmp(32'(got_q.size()), 32'h0);
      dbg_halt <= 1'b0;
      cmp_cmd(CMD_DATA, 3);
      cmp_cmd(CMD_FETCH, 3);
      wr(`IDX_DEBUG_HALT, 32'h1);
      dbg_halt <= 1'b1;
      pulse(8'h08);
      cmp_cmd(CMD_DATA, 3);
      $display("test debug halt done");
      // channel 3 now holds a null next address: resuming it must fail
      wr(`IDX_CH_SUSPEND, 32'h8);
      wr(`IDX_CH_RESUME, 32'h8);
      repeat (8) @(posedge clk_sys);
      chk(`IDX_CH_STATUS, 32'h0C0C);
      chk(`IDX_INT_FLAG, 32'h0802);
      cmp(32'(got_q.size()), 32'h0);
      $display("test resume on null next done");
      final_report();
   end
endmodule
`default_nettype wire
